// >>> shared/oledw_pkg.sv
// constants, field layouts and carrier types of the display command and memory writer
package oledw_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RST_LOW_NS  = 3000;
  localparam int RST_LOW_CYC   = (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_DRV_ON_MS   = 100;
  localparam int DRV_ON_CYC    = T_DRV_ON_MS * (1000000 / CLK_PERIOD_NS);
  // ****************************************
  // serial link framing
  // ****************************************
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h3C;
  localparam int CTRL_CO_BIT = 7;
  localparam int CTRL_DC_BIT = 6;
  // ****************************************
  // command bytes
  // ****************************************
  localparam logic [7:0] CMD_DISP_OFF  = 8'hAE;
  localparam logic [7:0] CMD_DISP_ON   = 8'hAF;
  localparam logic [7:0] CMD_CONTRAST  = 8'h81;
  localparam logic [7:0] CMD_CLK_DIV   = 8'hD5;
  localparam logic [7:0] CMD_PRECHARGE = 8'hD9;
  localparam logic [7:0] CMD_ADDR_MODE = 8'h20;
  localparam logic [7:0] CMD_START_OFS = 8'hD3;
  localparam logic [7:0] CMD_MUX_RATIO = 8'hA8;
  localparam logic [7:0] CMD_IREF_SEL  = 8'hAD;
  localparam logic [7:0] CMD_PIN_CFG   = 8'hDA;
  localparam logic [7:0] CMD_DESEL_LVL = 8'hDB;
  localparam logic [7:0] CMD_PUMP      = 8'h8D;
  localparam logic [7:0] CMD_SEG_NORM  = 8'hA0;
  localparam logic [7:0] CMD_SEG_REV   = 8'hA1;
  localparam logic [7:0] CMD_COM_NORM  = 8'hC0;
  localparam logic [7:0] CMD_COM_REV   = 8'hC8;
  localparam logic [7:0] MODE_PAGE     = 8'h02;
  // ****************************************
  // types and reset values
  // ****************************************
  typedef struct packed {
    logic       is_data;
    logic [7:0] val;
  } oledw_byte_s;
  typedef struct packed {
    logic [7:0] contrast;
    logic [7:0] clk_div;
    logic [7:0] precharge;
    logic [7:0] addr_mode;
    logic [5:0] start_line;
    logic       seg_remap;
    logic       com_remap;
    logic       display_on_cmd;
  } oledw_cfg_s;
  localparam oledw_cfg_s CFG_RST = '{contrast: 8'h7F, clk_div: 8'h80, precharge: 8'h22,
                                     addr_mode: MODE_PAGE, start_line: 6'h00, seg_remap: 1'b0,
                                     com_remap: 1'b0, display_on_cmd: 1'b0};
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK_A, I_CTRL, I_ACK_C, I_DATA, I_ACK_D, I_SKIP} oledw_i2c_e;
endpackage

// >>> core/oledw_fifo.sv
// the byte fifo module stands beside the interpreter in core/oledw_core.sv

// >>> core/oledw_core.sv
// serial command interpreter and page-addressed display memory writer
`timescale 1ns/1ps
module oledw_core
  import oledw_pkg::*;
#(
  parameter int ON_DELAY_CYC = oledw_pkg::DRV_ON_CYC,
  parameter int FIFO_DEPTH   = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // straps and reset pin
  input  wire logic             chip_reset_low_pin,
  input  wire logic             interface_select_pin,
  input  wire logic             slave_address_select_bit,
  // serial link
  input  wire logic             serial_clock_pin,
  input  wire logic             serial_data_input_pin,
  output logic                  serial_data_output_pin,
  output logic                  serial_data_oe,
  // panel readout
  input  wire logic             rd_en,
  input  wire logic [5:0]       rd_row,
  input  wire logic [6:0]       rd_col,
  output logic                  pix_valid,
  output logic                  pix,
  // status
  output oledw_pkg::oledw_cfg_s cfg,
  output logic                  drv_outputs_on,
  output logic [2:0]            page_ptr,
  output logic [6:0]            col_ptr
);
  import oledw_pkg::*;

  localparam int ONW = $clog2(ON_DELAY_CYC + 1);
  localparam int RW  = $clog2(RST_LOW_CYC + 1);

  typedef struct packed {
    logic [1:0]   scl_s;
    logic [1:0]   sda_s;
    logic [1:0]   cr_s;
    logic [1:0]   im_s;
    logic [1:0]   sa_s;
    logic         scl_p;
    logic         sda_p;
    oledw_i2c_e   ist;
    logic [3:0]   nbit;
    logic [7:0]   sh;
    logic         oe;
    logic         co;
    logic         dc;
    logic         ok;
    logic [RW-1:0]  rcnt;
    logic [ONW-1:0] on_cnt;
    logic         drv_on;
    logic         pend;
    logic [7:0]   pcmd;
    oledw_cfg_s   cfg;
    logic [2:0]   page;
    logic [6:0]   col;
    logic         pix_v;
    logic         pix;
  } oledw_core_st_s;

  // link inputs start at their idle high level, so no false edge follows reset
  localparam oledw_core_st_s ST_RST = '{ist: I_IDLE, cfg: CFG_RST, scl_s: 2'b11, sda_s: 2'b11,
                                        scl_p: 1'b1, sda_p: 1'b1, default: '0};

  oledw_core_st_s st_reg;
  oledw_core_st_s st_next;
  logic [7:0]     mem [1024];
  oledw_byte_s    push_data;
  logic           push;
  logic           fifo_in_ready;
  oledw_byte_s    pop_data;
  logic           pop_valid;
  logic           pop_ready;
  logic           mem_we;
  logic [9:0]     mem_wa;
  logic [7:0]     mem_wd;
  logic [5:0]     mem_row;
  logic [6:0]     mem_col;

  // ****************************************
  // received byte buffer
  // ****************************************
  oledw_fifo #(
    .WIDTH ($bits(oledw_byte_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  // readout owns the memory port, so draining stalls while it reads
  assign pop_ready = ~rd_en;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic in_rst;
    logic [7:0] b;
    st_next = st_reg;
    push = 1'b0;
    push_data = '0;
    mem_we = 1'b0;
    mem_wa = {st_reg.page, st_reg.col};
    mem_wd = pop_data.val;
    // pins pass two flip-flops first
    st_next.scl_s = {st_reg.scl_s[0], serial_clock_pin};
    st_next.sda_s = {st_reg.sda_s[0], serial_data_input_pin};
    st_next.cr_s = {st_reg.cr_s[0], chip_reset_low_pin};
    st_next.im_s = {st_reg.im_s[0], interface_select_pin};
    st_next.sa_s = {st_reg.sa_s[0], slave_address_select_bit};
    scl = st_reg.scl_s[1];
    sda = st_reg.sda_s[1];
    in_rst = ~st_reg.cr_s[1];
    st_next.scl_p = scl;
    st_next.sda_p = sda;
    rise = scl & ~st_reg.scl_p;
    fall = ~scl & st_reg.scl_p;
    start = scl & st_reg.scl_p & st_reg.sda_p & ~sda;
    stop = scl & st_reg.scl_p & ~st_reg.sda_p & sda;
    b = {st_reg.sh[6:0], sda};
    // link receiver; only listens in serial bus mode
    if (~st_reg.im_s[1] | in_rst) begin
      st_next.ist = I_IDLE;
      st_next.oe = 1'b0;
    end else if (start) begin
      st_next.ist = I_ADDR;
      st_next.nbit = 4'h0;
      st_next.oe = 1'b0;
    end else if (stop) begin
      st_next.ist = I_IDLE;
      st_next.oe = 1'b0;
    end else begin
      case (st_reg.ist)
        I_ADDR, I_CTRL, I_DATA: begin
          if (rise) begin
            st_next.sh = b;
            st_next.nbit = st_reg.nbit + 4'h1;
            if (st_reg.ist == I_DATA && st_reg.nbit == 4'h7) begin
              push = 1'b1;
              push_data = '{is_data: st_reg.dc, val: b};
              st_next.ok = fifo_in_ready;
            end
          end else if (fall && st_reg.nbit == 4'h8) begin
            st_next.nbit = 4'h0;
            if (st_reg.ist == I_ADDR) begin
              // write only, address bit 0 from the strap
              if (st_reg.sh[7:1] == {SLAVE_ADDR_BASE[6:1], st_reg.sa_s[1]} && !st_reg.sh[0]) begin
                st_next.oe = 1'b1;
                st_next.ist = I_ACK_A;
              end else begin
                st_next.ist = I_SKIP;
              end
            end else if (st_reg.ist == I_CTRL) begin
              st_next.co = st_reg.sh[CTRL_CO_BIT];
              st_next.dc = st_reg.sh[CTRL_DC_BIT];
              st_next.oe = 1'b1;
              st_next.ist = I_ACK_C;
            end else begin
              // a full buffer answers with a not-acknowledge
              st_next.oe = st_reg.ok;
              st_next.ist = st_reg.ok ? I_ACK_D : I_SKIP;
            end
          end
        end
        I_ACK_A, I_ACK_C, I_ACK_D: begin
          if (fall) begin
            st_next.oe = 1'b0;
            if (st_reg.ist == I_ACK_A) st_next.ist = I_CTRL;
            else if (st_reg.ist == I_ACK_C) st_next.ist = I_DATA;
            else st_next.ist = st_reg.co ? I_CTRL : I_DATA;
          end
        end
        I_IDLE, I_SKIP: begin
          st_next.oe = 1'b0;
        end
        default: begin
          st_next.ist = I_IDLE;
          st_next.oe = 1'b0;
        end
      endcase
    end
    // driver enable delay after display on
    if (st_reg.cfg.display_on_cmd & ~st_reg.drv_on) begin
      st_next.on_cnt = st_reg.on_cnt + 1'b1;
      if (st_reg.on_cnt == ONW'(ON_DELAY_CYC - 1)) st_next.drv_on = 1'b1;
    end
    // interpreter
    if (pop_valid & pop_ready & ~in_rst) begin
      if (pop_data.is_data) begin
        mem_we = 1'b1;
        st_next.col = st_reg.col + 7'h01;
      end else if (st_reg.pend) begin
        st_next.pend = 1'b0;
        case (st_reg.pcmd)
          CMD_CONTRAST: st_next.cfg.contrast = pop_data.val;
          CMD_CLK_DIV: st_next.cfg.clk_div = pop_data.val;
          CMD_PRECHARGE: st_next.cfg.precharge = pop_data.val;
          CMD_ADDR_MODE: st_next.cfg.addr_mode = pop_data.val;
          CMD_START_OFS: st_next.cfg.start_line = pop_data.val[5:0];
          default: st_next.pend = 1'b0;
        endcase
      end else begin
        casez (pop_data.val)
          CMD_DISP_OFF: begin
            st_next.cfg.display_on_cmd = 1'b0;
            st_next.drv_on = 1'b0;
            st_next.on_cnt = '0;
          end
          CMD_DISP_ON: begin
            st_next.cfg.display_on_cmd = 1'b1;
          end
          CMD_CONTRAST, CMD_CLK_DIV, CMD_PRECHARGE, CMD_ADDR_MODE, CMD_START_OFS,
          CMD_MUX_RATIO, CMD_IREF_SEL, CMD_PIN_CFG, CMD_DESEL_LVL, CMD_PUMP: begin
            st_next.pend = 1'b1;
            st_next.pcmd = pop_data.val;
          end
          8'b1011_0???: st_next.page = pop_data.val[2:0];
          8'b0000_????: st_next.col[3:0] = pop_data.val[3:0];
          8'b0001_0???: st_next.col[6:4] = pop_data.val[2:0];
          8'b01??_????: st_next.cfg.start_line = pop_data.val[5:0];
          CMD_SEG_NORM, CMD_SEG_REV: st_next.cfg.seg_remap = pop_data.val[0];
          CMD_COM_NORM: st_next.cfg.com_remap = 1'b0;
          CMD_COM_REV: st_next.cfg.com_remap = 1'b1;
          default: st_next.pend = 1'b0;
        endcase
      end
    end
    // reset pin: defaults once held low long enough
    if (in_rst) begin
      if (st_reg.rcnt != RW'(RST_LOW_CYC)) st_next.rcnt = st_reg.rcnt + 1'b1;
      if (st_reg.rcnt >= RW'(RST_LOW_CYC - 1)) begin
        st_next.cfg = CFG_RST;
        st_next.page = 3'h0;
        st_next.col = 7'h00;
        st_next.pend = 1'b0;
        st_next.drv_on = 1'b0;
        st_next.on_cnt = '0;
      end
    end else begin
      st_next.rcnt = '0;
    end
    // readout with re-mapping and start line
    mem_row = 6'((st_reg.cfg.com_remap ? ~rd_row : rd_row) + st_reg.cfg.start_line);
    mem_col = st_reg.cfg.seg_remap ? ~rd_col : rd_col;
    st_next.pix_v = rd_en;
    if (rd_en) st_next.pix = mem[{mem_row[5:3], mem_col}][mem_row[2:0]];
    // pixel stays dark while the drivers are off, even without a new readout
    if (!st_reg.drv_on) st_next.pix = 1'b0;
  end

  // ****************************************
  // registers and display memory
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) st_reg <= ST_RST;
    else st_reg <= st_next;
  end

  // byte lands page-wide at one column, bit 0 on the page's top row
  always_ff @(posedge clk) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

  assign serial_data_output_pin = 1'b0;
  assign serial_data_oe         = st_reg.oe;
  assign pix_valid              = st_reg.pix_v;
  assign pix                    = st_reg.pix;
  assign cfg                    = st_reg.cfg;
  assign drv_outputs_on         = st_reg.drv_on;
  assign page_ptr               = st_reg.page;
  assign col_ptr                = st_reg.col;
endmodule

// ****************************************
// received byte fifo
// ****************************************
module oledw_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } oledw_fifo_st_s;
  oledw_fifo_st_s   st_reg;
  oledw_fifo_st_s   st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = st_reg.cnt != DEPTH[AW:0];
  assign out_valid = st_reg.cnt != '0;
  assign out_data  = mem[st_reg.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) st_next.wp = st_reg.wp + 1'b1;
    if (pop) st_next.rp = st_reg.rp + 1'b1;
    if (push & ~pop) st_next.cnt = st_reg.cnt + 1'b1;
    else if (pop & ~push) st_next.cnt = st_reg.cnt - 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) st_reg <= '0;
    else st_reg <= st_next;
  end

  always_ff @(posedge clk) begin
    if (push) mem[st_reg.wp] <= in_data;
  end
endmodule

// >>> bench/oledw_core_properties.sv
// port-level checks of the display command and memory writer
`timescale 1ns/1ps
module oledw_core_properties
  import oledw_pkg::*;
#(
  parameter int ON_DELAY_CYC = 50
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  sys_rst,
  // straps and link
  input wire logic                  chip_reset_low_pin,
  input wire logic                  interface_select_pin,
  input wire logic                  serial_clock_pin,
  input wire logic                  serial_data_oe,
  // readout and status
  input wire logic                  rd_en,
  input wire logic                  pix_valid,
  input wire logic                  pix,
  input wire oledw_pkg::oledw_cfg_s cfg,
  input wire logic                  drv_outputs_on,
  input wire logic [2:0]            page_ptr,
  input wire logic [6:0]            col_ptr
);
  // ****************************************
  // cycle counters
  // ****************************************
  int on_cnt;
  int low_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      on_cnt  <= 0;
      low_cnt <= 0;
    end else begin
      on_cnt  <= !cfg.display_on_cmd ? 0 : (on_cnt > ON_DELAY_CYC + 8 ? on_cnt : on_cnt + 1);
      low_cnt <= chip_reset_low_pin ? 0 : (low_cnt > 400 ? low_cnt : low_cnt + 1);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_readout_flag: assert property (rd_en |=> pix_valid)
    else $error("readout flag missing");
  a_dark_when_off: assert property (!drv_outputs_on [*2] |-> !pix)
    else $error("pixel lit while drivers off");
  a_on_delay_min: assert property ($rose(drv_outputs_on) |-> on_cnt >= ON_DELAY_CYC - 2)
    else $error("drivers on too early");
  a_on_delay_max: assert property (on_cnt == ON_DELAY_CYC + 3 |-> drv_outputs_on)
    else $error("drivers on too late");
  a_off_prompt: assert property ($fell(cfg.display_on_cmd) |-> ##[0:1] !drv_outputs_on)
    else $error("drivers stay on after off");
  a_quiet_unselected: assert property (!interface_select_pin [*4] |-> !serial_data_oe)
    else $error("acknowledge while unselected");
  a_ack_after_fall: assert property ($rose(serial_data_oe) |-> !$past(serial_clock_pin, 2))
    else $error("acknowledge not in clock low");
  a_ack_stands: assert property ($rose(serial_data_oe) |=> serial_data_oe [*8])
    else $error("acknowledge too short");
  a_chip_defaults: assert property (low_cnt > 305 |-> cfg == CFG_RST && !drv_outputs_on
    && page_ptr == 3'h0 && col_ptr == 7'h00)
    else $error("settings not at defaults in reset");
  a_short_keep: assert property (low_cnt inside {[4:290]} |-> $stable(cfg))
    else $error("settings lost before minimum low");
  c_drivers_on: cover property ($rose(drv_outputs_on));
  c_ack_given: cover property ($rose(serial_data_oe));
  c_long_reset: cover property (low_cnt == 306);
endmodule
bind oledw_core oledw_core_properties #(.ON_DELAY_CYC(ON_DELAY_CYC)) oledw_core_properties_inst (
  .clk(clk), .sys_rst(sys_rst), .chip_reset_low_pin(chip_reset_low_pin),
  .interface_select_pin(interface_select_pin), .serial_clock_pin(serial_clock_pin),
  .serial_data_oe(serial_data_oe), .rd_en(rd_en), .pix_valid(pix_valid), .pix(pix), .cfg(cfg),
  .drv_outputs_on(drv_outputs_on), .page_ptr(page_ptr), .col_ptr(col_ptr));

// >>> bench/oledw_host_model.sv
// behavioural two-wire bus host driving the device link
`timescale 1ns/1ps
module oledw_host_model (
  // clock
  input  wire logic clk,
  // device side of the data line
  input  wire logic dev_oe,
  input  wire logic dev_out,
  // link
  output logic      scl,
  output logic      sda
);
  logic m_sda = 1'b1;
  initial scl = 1'b1;
  // open drain with pull-up: low if either party pulls
  assign sda = m_sda & (dev_oe ? dev_out : 1'b1);
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start_cond();
    m_sda = 1'b1;
    scl   = 1'b1;
    wt(8);
    m_sda = 1'b0;
    wt(8);
    scl = 1'b0;
    wt(4);
  endtask
  task automatic stop_cond();
    m_sda = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(8);
    m_sda = 1'b1;
    wt(8);
  endtask
  // msb first, then the acknowledge slot with the line released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      m_sda = b[i];
      wt(4);
      scl = 1'b1;
      wt(8);
      scl = 1'b0;
      wt(4);
    end
    m_sda = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(4);
    ack = !sda;
    wt(4);
    scl = 1'b0;
    wt(4);
  endtask
endmodule

// >>> bench/tb_oledw_core.sv
// self-checking bench for the display command and memory writer
`timescale 1ns/1ps
module tb_oledw_core;
  import oledw_pkg::*;
  localparam int         ON_CYC = 200;
  localparam logic [7:0] WR     = 8'h7A;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       chip_reset_low_pin = 1'b1;
  logic       interface_select_pin = 1'b1;
  logic       slave_address_select_bit = 1'b1;
  logic       rd_en = 1'b0;
  logic [5:0] rd_row = 6'h00;
  logic [6:0] rd_col = 7'h00;
  logic       scl, sda, oe, out_pin, pix_valid, pix, drv_on;
  logic [2:0] page_ptr;
  logic [6:0] col_ptr;
  logic [7:0] q[$];
  oledw_cfg_s cfg, exp_cfg;
  int         miscompares = 0;
  int         checks_done = 0;
  int         cycles = 0;
  always #5 clk = ~clk;
  oledw_core #(.ON_DELAY_CYC(ON_CYC)) oledw_core_inst (
    .clk(clk), .sys_rst(sys_rst), .chip_reset_low_pin(chip_reset_low_pin),
    .interface_select_pin(interface_select_pin), .slave_address_select_bit(slave_address_select_bit),
    .serial_clock_pin(scl), .serial_data_input_pin(sda), .serial_data_output_pin(out_pin),
    .serial_data_oe(oe), .rd_en(rd_en), .rd_row(rd_row), .rd_col(rd_col), .pix_valid(pix_valid),
    .pix(pix), .cfg(cfg), .drv_outputs_on(drv_on), .page_ptr(page_ptr), .col_ptr(col_ptr));
  oledw_host_model oledw_host_model_inst (
    .clk(clk), .dev_oe(oe), .dev_out(out_pin), .scl(scl), .sda(sda));
  // ****************************************
  // tasks
  // ****************************************
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic check_cfg(input oledw_cfg_s exp);
    checks_done++;
    if (cfg !== exp) begin
      miscompares++;
      $display("mismatch at %0t: settings %0h expected %0h", $time, cfg, exp);
    end
  endtask
  // address then bytes; the device must refuse the byte at index nack_at
  task automatic frame(input logic [7:0] b[$], input int nack_at = -1);
    logic ack;
    oledw_host_model_inst.start_cond();
    foreach (b[i]) begin
      oledw_host_model_inst.send_byte(b[i], ack);
      check(ack, i != nack_at, "acknowledge");
      if (!ack) break;
    end
    oledw_host_model_inst.stop_cond();
  endtask
  task automatic peek(input int row, input int col, input logic exp);
    @(negedge clk);
    rd_en  = 1'b1;
    rd_row = row[5:0];
    rd_col = col[6:0];
    @(negedge clk);
    rd_en = 1'b0;
    check({pix_valid, pix}, {1'b1, exp}, "pixel");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    wt(4);
    sys_rst = 1'b0;
    wt(12);
    check_cfg(CFG_RST);
    check({drv_on, page_ptr, col_ptr}, 32'h0, "status");
    frame({8'h78, 8'h00}, 0);
    frame({WR, 8'h00, 8'h81, 8'h57, 8'hD5, 8'h90, 8'hD9, 8'h42, 8'h20, 8'h02});
    exp_cfg = CFG_RST;
    exp_cfg.contrast  = 8'h57;
    exp_cfg.clk_div   = 8'h90;
    exp_cfg.precharge = 8'h42;
    exp_cfg.addr_mode = 8'h02;
    check_cfg(exp_cfg);
    frame({WR, 8'h00, 8'hB3, 8'h05, 8'h11});
    check({page_ptr, col_ptr}, {3'h3, 7'h15}, "pointers");
    frame({WR, 8'h40, 8'h81, 8'h7E});
    frame({WR, 8'h80, 8'hB6, 8'hC0, 8'h3C});
    check({page_ptr, col_ptr}, {3'h6, 7'h18}, "pointers");
    frame({WR, 8'h00, 8'hAF});
    check({cfg.display_on_cmd, drv_on}, 2'b10, "turn-on");
    wt(ON_CYC);
    check(drv_on, 1'b1, "drivers");
    peek(24, 8'h15, 1'b1);
    peek(25, 8'h15, 1'b0);
    peek(31, 8'h15, 1'b1);
    peek(25, 8'h16, 1'b1);
    peek(50, 8'h17, 1'b1);
    peek(48, 8'h17, 1'b0);
    frame({WR, 8'h00, 8'hA1, 8'hC8});
    peek(39, 106, 1'b1);
    peek(38, 106, 1'b0);
    frame({WR, 8'h00, 8'hA0, 8'hC0, 8'hD3, 8'h08});
    peek(16, 8'h15, 1'b1);
    peek(17, 8'h15, 1'b0);
    wt(1);
    rd_en = 1'b1;
    q = {WR, 8'h40};
    repeat (17) q.push_back(8'h5A);
    frame(q, 18);
    rd_en = 1'b0;
    wt(40);
    check(col_ptr, 7'h28, "column");
    frame({WR, 8'h00, 8'h0F, 8'h17});
    frame({WR, 8'h40, 8'h01, 8'h02});
    check(col_ptr, 7'h01, "wrap");
    frame({WR, 8'h00, 8'hAE});
    check(drv_on, 1'b0, "drivers");
    peek(16, 8'h15, 1'b0);
    slave_address_select_bit = 1'b0;
    wt(5);
    frame({8'h78, 8'h00, 8'hB1});
    check(page_ptr, 3'h1, "page");
    slave_address_select_bit = 1'b1;
    wt(5);
    interface_select_pin = 1'b0;
    wt(5);
    frame({WR, 8'h00, 8'h81, 8'h11}, 0);
    interface_select_pin = 1'b1;
    wt(5);
    chip_reset_low_pin = 1'b0;
    wt(100);
    chip_reset_low_pin = 1'b1;
    wt(10);
    check(cfg.contrast, 8'h57, "short reset");
    chip_reset_low_pin = 1'b0;
    wt(320);
    check_cfg(CFG_RST);
    check({drv_on, page_ptr, col_ptr}, 32'h0, "status");
    chip_reset_low_pin = 1'b1;
    wt(10);
    end_of_test();
  end
endmodule
